// [gpm_pkg.sv]
// gpm_pkg: shared constants and types for the gpio port with pin mux
// assumes one system clock; no register bus, all controls are ports
package gpm_pkg;
    localparam int NUM_PORTS   = 5;
    localparam int PORT_W      = 8;
    localparam int NUM_PINS    = 36;
    localparam int PORT2_PINS  = 8;
    localparam int PORT3_PINS  = 8;
    localparam int PORT4_PINS  = 4;
    localparam int MODE_W      = 3;
    localparam int FUNC_W      = 3;
    // drive modes, analog first so reset leaves buffers off
    typedef enum logic [2:0] {
        GPM_DM_ANALOG,
        GPM_DM_INPUT,
        GPM_DM_WKUP_STDN,
        GPM_DM_STUP_WKDN,
        GPM_DM_OD_STDN,
        GPM_DM_OD_STUP,
        GPM_DM_STRONG,
        GPM_DM_WEAK
    } gpm_mode_t;
    // function select per pin
    typedef enum logic [2:0] {
        GPM_FN_GPIO,
        GPM_FN_ANALOG,
        GPM_FN_FABRIC,
        GPM_FN_ALT1,
        GPM_FN_ALT2,
        GPM_FN_ALT3,
        GPM_FN_LP1,
        GPM_FN_LP2
    } gpm_func_t;
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [2:0] FUNC_RST = 3'h0;
    localparam gpm_func_t  FN_UART  = GPM_FN_ALT2;
    localparam gpm_func_t  FN_I2C   = GPM_FN_LP1;
    localparam gpm_func_t  FN_DEBUG = GPM_FN_LP1;
    localparam gpm_func_t  FN_SPI   = GPM_FN_LP2;
endpackage : gpm_pkg

// [gpm_port.sv]
// gpm_port: 36-pin gpio block with drive modes, mux and per-port irq
// assumes pads are outside; pad inputs synchronous only in name, so synchronised here
`timescale 1ns/10ps
`default_nettype none
module gpm_port (
    input  wire logic                                   clk_sys,
    input  wire logic                                   resetn,
    input  wire logic [gpm_pkg::NUM_PINS-1:0]           pin_in,
    output logic      [gpm_pkg::NUM_PINS-1:0]           pin_out,
    output logic      [gpm_pkg::NUM_PINS-1:0]           pin_oe,
    output logic      [gpm_pkg::NUM_PINS-1:0]           pin_ie,
    output logic      [gpm_pkg::NUM_PINS*3-1:0]         pin_drive,
    output logic      [gpm_pkg::NUM_PINS-1:0]           pin_lvttl,
    output logic      [gpm_pkg::NUM_PINS-1:0]           pin_slow,
    input  wire logic [gpm_pkg::NUM_PINS*3-1:0]         cfg_mode,
    input  wire logic [gpm_pkg::NUM_PINS-1:0]           cfg_lvttl,
    input  wire logic [gpm_pkg::NUM_PINS-1:0]           cfg_slow,
    input  wire logic [gpm_pkg::NUM_PINS-1:0]           cfg_ibuf_en,
    input  wire logic [gpm_pkg::NUM_PINS-1:0]           cfg_obuf_en,
    input  wire logic [gpm_pkg::NUM_PINS*3-1:0]         cfg_func,
    input  wire logic                                   dout_we,
    input  wire logic [gpm_pkg::NUM_PINS-1:0]           dout_wdata,
    output logic      [gpm_pkg::NUM_PINS-1:0]           dout_q,
    output logic      [gpm_pkg::NUM_PINS-1:0]           pin_state,
    input  wire logic [gpm_pkg::NUM_PINS-1:0]           irq_en,
    input  wire logic [gpm_pkg::NUM_PINS-1:0]           irq_clr,
    output logic      [gpm_pkg::NUM_PINS-1:0]           irq_flag,
    output logic      [gpm_pkg::NUM_PORTS-1:0]          port_irq,
    input  wire logic [gpm_pkg::NUM_PINS-1:0]           fab_out,
    input  wire logic [gpm_pkg::NUM_PINS-1:0]           fab_oe,
    input  wire logic [gpm_pkg::NUM_PINS*6-1:0]         alt_out,
    input  wire logic [gpm_pkg::NUM_PINS*6-1:0]         alt_oe,
    output logic      [gpm_pkg::NUM_PINS-1:0]           periph_in,
    output logic      [gpm_pkg::NUM_PINS-1:0]           i2c_pin
);
    localparam int N = gpm_pkg::NUM_PINS;

    logic [N-1:0] sync1_q;
    logic [N-1:0] sync2_q;
    logic [N-1:0] prev_q;
    logic [N-1:0] dout_d;
    logic [N-1:0] src_out;
    logic [N-1:0] src_oe;
    logic [N-1:0] is_i2c;
    logic [N*3-1:0] mode_eff;
    logic [N-1:0] edge_det;

    // output data storage
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            dout_q <= '0;
        end else if (dout_we) begin
            dout_q <= dout_wdata;
        end
    end
    assign dout_d = dout_q;

    // two-flop synchroniser; first stage feeds only the second
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pin
            gpm_pkg::gpm_func_t fn;
            assign fn = gpm_pkg::gpm_func_t'(cfg_func[g*3 +: 3]);
            // one function per pin; the select is a single enum value
            always_comb begin
                src_out[g] = dout_d[g];
                src_oe[g]  = 1'b1;
                case (fn)
                    gpm_pkg::GPM_FN_GPIO: begin
                        src_out[g] = dout_d[g];
                        src_oe[g]  = 1'b1;
                    end
                    gpm_pkg::GPM_FN_ANALOG: begin
                        src_out[g] = 1'b0;
                        src_oe[g]  = 1'b0;
                    end
                    gpm_pkg::GPM_FN_FABRIC: begin
                        src_out[g] = fab_out[g];
                        src_oe[g]  = fab_oe[g];
                    end
                    default: begin
                        src_out[g] = alt_out[g*6 + (int'(fn) - 3)];
                        src_oe[g]  = alt_oe[g*6 + (int'(fn) - 3)];
                    end
                endcase
            end
            // i2c lives in the first low-power slot
            assign is_i2c[g] = (fn == gpm_pkg::FN_I2C);
            // i2c pins must never drive high: force strong-down open drain
            assign mode_eff[g*3 +: 3] = is_i2c[g] ? 3'(gpm_pkg::GPM_DM_OD_STDN)
                                                  : cfg_mode[g*3 +: 3];
            assign edge_det[g] = sync2_q[g] ^ prev_q[g];
        end
    endgenerate

    // pad controls, registered so outputs come from flops
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pin_drive <= {N{gpm_pkg::MODE_RST}};
            pin_oe    <= '0;
            pin_ie    <= '0;
            pin_out   <= '0;
            pin_lvttl <= '0;
            pin_slow  <= '0;
            i2c_pin   <= '0;
        end else begin
            pin_drive <= mode_eff;
            for (int i = 0; i < N; i++) begin
                // analog mode turns both buffers off whatever the enables say
                pin_oe[i] <= cfg_obuf_en[i] & src_oe[i] &
                             (mode_eff[i*3 +: 3] > 3'(gpm_pkg::GPM_DM_INPUT));
                pin_ie[i] <= cfg_ibuf_en[i] &
                             (mode_eff[i*3 +: 3] != 3'(gpm_pkg::GPM_DM_ANALOG));
            end
            pin_out   <= src_out;
            pin_lvttl <= cfg_lvttl;
            pin_slow  <= cfg_slow;
            i2c_pin   <= is_i2c;
        end
    end

    // pin state readback and peripheral input
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pin_state <= '0;
            periph_in <= '0;
        end else begin
            pin_state <= sync2_q & pin_ie;
            periph_in <= sync2_q & pin_ie;
        end
    end

    // sticky flags on either edge; a new edge beats a clear
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            irq_flag <= '0;
        end else begin
            irq_flag <= (irq_flag & ~irq_clr) | (edge_det & irq_en);
        end
    end

    // merge per port; port 4 only has four pins
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            port_irq <= '0;
        end else begin
            for (int p = 0; p < gpm_pkg::NUM_PORTS; p++) begin
                port_irq[p] <= |((irq_flag & ~irq_clr | edge_det & irq_en) >> (p*gpm_pkg::PORT_W)
                                 & 36'h0ff);
            end
        end
    end

    AST_I2C_OD: assert property (@(posedge clk_sys) disable iff (!resetn)
        is_i2c[0] |=> pin_drive[2:0] == 3'(gpm_pkg::GPM_DM_OD_STDN))
        else $error("i2c pin not open drain");
    AST_RESET_OFF: assert property (@(posedge clk_sys)
        !resetn |=> (pin_oe == '0 && pin_ie == '0 && pin_drive == '0))
        else $error("pins not disabled in reset");
    AST_DOUT: assert property (@(posedge clk_sys) disable iff (!resetn)
        dout_we |=> dout_q == $past(dout_wdata))
        else $error("output data not stored");
    AST_SET_WINS: assert property (@(posedge clk_sys) disable iff (!resetn)
        (edge_det[0] && irq_en[0]) |=> irq_flag[0])
        else $error("interrupt edge lost");
    AST_SYNC: assert property (@(posedge clk_sys) disable iff (!resetn)
        pin_in[0] ##1 pin_in[0] ##1 pin_ie[0] |=> pin_state[0])
        else $error("pin state lag wrong");
    AST_PORT_IRQ: assert property (@(posedge clk_sys) disable iff (!resetn)
        irq_flag[3] && !irq_clr[3] |=> port_irq[0])
        else $error("port request missing");
    AST_CLEAR: assert property (@(posedge clk_sys) disable iff (!resetn)
        irq_clr[1] && !edge_det[1] |=> !irq_flag[1])
        else $error("flag not cleared");
    AST_ANALOG: assert property (@(posedge clk_sys) disable iff (!resetn)
        mode_eff[5:3] == 3'h0 |=> !pin_oe[1] && !pin_ie[1])
        else $error("analog pin buffer on");
    AST_INPUT_ONLY: assert property (@(posedge clk_sys) disable iff (!resetn)
        mode_eff[5:3] == 3'(gpm_pkg::GPM_DM_INPUT) |=> !pin_oe[1] && pin_ie[1] == $past(cfg_ibuf_en[1]))
        else $error("input only pin drives");
    AST_PORT4_IRQ: assert property (@(posedge clk_sys) disable iff (!resetn)
        irq_flag[33] && !irq_clr[33] |=> port_irq[4])
        else $error("short port request missing");
    AST_PAD_CFG: assert property (@(posedge clk_sys) disable iff (!resetn)
        resetn |=> pin_slow == $past(cfg_slow) && pin_lvttl == $past(cfg_lvttl))
        else $error("threshold or slew not passed on");
    AST_GPIO_OUT: assert property (@(posedge clk_sys) disable iff (!resetn)
        cfg_func[2:0] == 3'(gpm_pkg::GPM_FN_GPIO) |=> pin_out[0] == $past(dout_q[0]))
        else $error("gpio pin not driven from output data");
    AST_FABRIC: assert property (@(posedge clk_sys) disable iff (!resetn)
        cfg_func[32:30] == 3'(gpm_pkg::GPM_FN_FABRIC) |=> pin_out[10] == $past(fab_out[10]))
        else $error("fabric source not selected");
    AST_STATE_GATED: assert property (@(posedge clk_sys) disable iff (!resetn)
        !pin_ie[2] |=> !pin_state[2] && !periph_in[2])
        else $error("pin state seen with input buffer off");
endmodule : gpm_port
`default_nettype wire

// [gpm_pad.sv]
// gpm_pad: pad model, outside circuitry seen through each pin
// assumes pad drives when pin_oe is high, else the outside level wins
`timescale 1ns/10ps
`default_nettype none
module gpm_pad (
    input  wire logic [gpm_pkg::NUM_PINS-1:0] pin_out,
    input  wire logic [gpm_pkg::NUM_PINS-1:0] pin_oe,
    input  wire logic [gpm_pkg::NUM_PINS-1:0] ext_lvl,
    output logic      [gpm_pkg::NUM_PINS-1:0] pin_in
);
    // released pins follow the outside level, never the last driven one
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : gpm_pad
`default_nettype wire

// [tb.sv]
// tb: directed checks of gpm_port through a pad model
// assumes gpm_pkg, gpm_port and gpm_pad compiled first
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
    localparam int N = gpm_pkg::NUM_PINS;
    logic clk_sys = 1'b0, resetn = 1'b0, dout_we = 1'b0;
    logic [N-1:0] pin_in, pin_out, pin_oe, pin_ie, pin_lvttl, pin_slow, dout_q, pin_state;
    logic [N-1:0] irq_flag, periph_in, i2c_pin, ext_lvl, fab_out, fab_oe;
    logic [N-1:0] cfg_lvttl, cfg_slow, cfg_ibuf_en, cfg_obuf_en, dout_wdata, irq_en, irq_clr;
    logic [N*3-1:0] pin_drive, cfg_mode, cfg_func;
    logic [N*6-1:0] alt_out, alt_oe;
    logic [4:0]     port_irq;
    int             checks = 0, fail_count = 0;
    always #12.5 clk_sys = ~clk_sys;
    gpm_port gpm_port_i (.clk_sys, .resetn, .pin_in, .pin_out, .pin_oe, .pin_ie, .pin_drive,
        .pin_lvttl, .pin_slow, .cfg_mode, .cfg_lvttl, .cfg_slow, .cfg_ibuf_en, .cfg_obuf_en,
        .cfg_func, .dout_we, .dout_wdata, .dout_q, .pin_state, .irq_en, .irq_clr, .irq_flag,
        .port_irq, .fab_out, .fab_oe, .alt_out, .alt_oe, .periph_in, .i2c_pin);
    gpm_pad gpm_pad_i (.pin_out, .pin_oe, .ext_lvl, .pin_in);
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask : step
    task automatic end_of_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    task automatic t_modes;
        for (int i = 0; i < 8; i++) begin
            cfg_mode = {N{i[2:0]}};
            step(2);
            `CHK(pin_drive[15+:3], i[2:0])
            `CHK(pin_oe[5], i > 1)
            `CHK(pin_ie[5], i != 0)
        end
        cfg_obuf_en = '0;
        cfg_mode = {N{3'h6}};
        step(2);
        `CHK(pin_oe, 36'h0)
        cfg_obuf_en = '1;
        $display("done modes");
    endtask : t_modes
    task automatic t_data;
        cfg_lvttl = 36'h5_a5a5_0f0f;
        cfg_slow = ~cfg_lvttl;
        dout_wdata = 36'h9_a5c3_1e77;
        dout_we = 1'b1;
        step(1);
        dout_we = 1'b0;
        `CHK(dout_q, 36'h9_a5c3_1e77)
        step(4);
        `CHK(pin_out, 36'h9_a5c3_1e77)
        `CHK(pin_state, 36'h9_a5c3_1e77)
        `CHK(periph_in, 36'h9_a5c3_1e77)
        `CHK(pin_lvttl, 36'h5_a5a5_0f0f)
        `CHK(pin_slow, 36'ha_5a5a_f0f0)
        $display("done data");
    endtask : t_data
    task automatic t_irq;
        cfg_mode = {N{3'h1}};
        ext_lvl = '0;
        irq_clr = '1;
        step(6);
        irq_clr = '0;
        irq_en = 36'h2_0000_0009;
        ext_lvl = 36'h2_0000_000d;
        step(2);
        `CHK(port_irq, 5'h00)
        step(4);
        `CHK(irq_flag, 36'h2_0000_0009)
        `CHK(port_irq, 5'h11)
        irq_clr = 36'h2_0000_0009;
        step(1);
        irq_clr = '0;
        step(1);
        `CHK(port_irq, 5'h00)
        `CHK(irq_flag, 36'h0)
        // falling edge on pin 0 meets its clear in one cycle
        ext_lvl = 36'h2_0000_000c;
        step(2);
        irq_clr = 36'h0_0000_0001;
        step(1);
        irq_clr = '0;
        `CHK(irq_flag, 36'h0_0000_0001)
        `CHK(port_irq, 5'h01)
        $display("done irq");
    endtask : t_irq
    task automatic t_mux;
        cfg_mode = {N{3'h6}};
        dout_wdata = '0;
        dout_we = 1'b1;
        {alt_out[55], alt_oe[55], alt_out[76], alt_oe[76]} = 4'hf;
        {alt_out[78], alt_oe[78], alt_out[86], alt_oe[86]} = 4'hf;
        fab_out[10] = 1'b1;
        cfg_func[27+:3] = gpm_pkg::FN_UART;
        cfg_func[30+:3] = gpm_pkg::GPM_FN_FABRIC;
        cfg_func[33+:3] = gpm_pkg::GPM_FN_ANALOG;
        cfg_func[36+:3] = gpm_pkg::FN_SPI;
        cfg_func[39+:3] = gpm_pkg::GPM_FN_ALT1;
        cfg_func[42+:3] = gpm_pkg::GPM_FN_ALT3;
        step(1);
        dout_we = 1'b0;
        step(1);
        `CHK(pin_out[9], 1'b1)
        `CHK(pin_out[14:9], 6'h3b)
        `CHK(pin_oe[14:9], 6'h39)
        cfg_func[0+:3] = gpm_pkg::FN_I2C;
        cfg_func[27+:3] = gpm_pkg::FN_I2C;
        step(2);
        `CHK(pin_drive[27+:3], 3'h4)
        `CHK(pin_drive[2:0], 3'h4)
        `CHK(i2c_pin[9], 1'b1)
        `CHK(i2c_pin, 36'h0_0000_0201)
        $display("done mux");
    endtask : t_mux
    initial begin
        {cfg_lvttl, cfg_slow, dout_wdata, irq_en, irq_clr, ext_lvl, fab_out, fab_oe} = '0;
        {cfg_mode, cfg_func, alt_out, alt_oe} = '0;
        {cfg_ibuf_en, cfg_obuf_en} = '1;
        step(20);
        `CHK(pin_oe | pin_ie | pin_drive[35:0] | irq_flag, 36'h0)
        resetn = 1'b1;
        t_modes();
        t_data();
        t_irq();
        t_mux();
        end_of_test();
    end
    initial begin
        #50000;
        fail_count++;
        end_of_test();
    end
endmodule : tb
`default_nettype wire
